// ---- pkg/mbwc_defines.vh ----
// constants for the serial query handler: codes, addresses, crc
//
// Summary of operation
// [RULE_01] coil-write reply: address, function, start coil, coil count, crc.
// [RULE_02] master pads an odd coil data byte count up to even.
// [RULE_03] register-write query: address, function, start, count, byte count, values, crc.
// [RULE_04] the one-byte count field is a byte count, not a register count.
// [RULE_05] register-write reply: address, function, start, register count, crc.
// [RULE_06] master never broadcasts a multi-register write.
// [RULE_07] every addressed non-broadcast query gets a reply; errors give exceptions. The handler drops queries longer than 64 bytes unanswered.
// [RULE_08] exception frame: address, function plus 80h, exception code, crc.
// [RULE_09] codes: 01h unsupported function, 02h bad address, 03h bad format.
// [RULE_10] value outside a register's range is rejected with 21h.
// [RULE_11] locked-while-running, commit while running, fault writes, read-only writes give 22h.
// [RULE_12] register writes reach volatile storage only until committed.
// [RULE_13] single-register write of any value to 0900h commits pending data.
// [RULE_14] commit progress is shown on status coil 001Ah.
// [RULE_15] master commits sparingly; storage wears after about 100,000 writes.
// [RULE_16] progress coil reads 1 while storing, 0 otherwise.
// [RULE_17] a query with bad crc is dropped without action or reply.
`ifndef MBWC_DEFINES_VH
`define MBWC_DEFINES_VH

`define MBWC_BCAST_ADDR   8'h00
`define MBWC_FN_WR_REG    8'h06
`define MBWC_FN_WR_COILS  8'h0F
`define MBWC_FN_WR_REGS   8'h10
`define MBWC_EXC_FLAG     8'h80
`define MBWC_EX_FUNC      8'h01
`define MBWC_EX_ADDR      8'h02
`define MBWC_EX_FORMAT    8'h03
`define MBWC_EX_RANGE     8'h21
`define MBWC_EX_BUSY      8'h22
`define MBWC_COMMIT_REG   16'h0900
`define MBWC_PROGRESS_COIL 16'h001A
`define MBWC_LEN_SINGLE   16'h0008
`define MBWC_LEN_MULTI    16'h0009
`define MBWC_LEN_MIN      16'h0004
`define MBWC_RESP_NORMAL  4'h6
`define MBWC_RESP_EXC     4'h3
`define MBWC_CRC_INIT     16'hFFFF
`define MBWC_CRC_POLY     16'hA001

`endif

// ---- logic/mbwc_crc16.v ----
// crc-16 byte accumulator for the serial frames
`timescale 1ns/1ps
`default_nettype none
`include "mbwc_defines.vh"

module mbwc_crc16 (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clr,
    input  wire        en,
    input  wire [7:0]  data,
    output reg  [15:0] crc_q
);
    function [15:0] crc_step;
        input [15:0] c;
        input [7:0]  d;
        integer k;
        reg [15:0] t;
        begin
            t = c ^ {8'h00, d};
            for (k = 0; k < 8; k = k + 1) begin
                if (t[0])
                    t = (t >> 1) ^ `MBWC_CRC_POLY;
                else
                    t = t >> 1;
            end
            crc_step = t;
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            crc_q <= `MBWC_CRC_INIT;
        else if (clr)
            crc_q <= `MBWC_CRC_INIT;
        else if (en)
            crc_q <= crc_step(crc_q, data);
    end
endmodule // mbwc_crc16
`default_nettype wire

// ---- logic/mbwc_top.v ----
// query handler for multi-write, exception replies and storage commit
`timescale 1ns/1ps
`default_nettype none
`include "mbwc_defines.vh"

module mbwc_top #(
    parameter BUF_AW = 6
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire [7:0]  slave_addr,
    input  wire [7:0]  rx_byte,
    input  wire        rx_valid,
    input  wire        rx_frame_end,
    output reg  [7:0]  tx_byte_q,
    output reg         tx_valid_q,
    output reg         tx_last_q,
    input  wire        tx_ready,
    input  wire        drive_running,
    input  wire        drive_fault,
    output reg  [15:0] item_addr_q,
    output reg  [15:0] item_value_q,
    output reg         item_coil_q,
    input  wire        item_exists,
    input  wire        item_read_only,
    input  wire        item_run_locked,
    input  wire        item_in_range,
    output wire        wr_en,
    output reg         nv_commit_start_q,
    input  wire        nv_commit_done,
    output reg         commit_progress_flag_q
);
    localparam DEPTH = 1 << BUF_AW;
    localparam LEN_W = BUF_AW + 1;

    localparam ST_IDLE  = 5'h01;
    localparam ST_CHECK = 5'h02;
    localparam ST_VALID = 5'h04;
    localparam ST_WRITE = 5'h08;
    localparam ST_TX    = 5'h10;

    reg        rst_m_q;
    reg        rst_n_q;
    reg [4:0]  state_q;
    reg [7:0]  buf_q [0:DEPTH-1];
    reg [LEN_W-1:0] len_q;
    reg        ovf_q;
    reg        exc_q;
    reg [7:0]  exc_code_q;
    reg        bcast_q;
    reg [15:0] idx_q;
    reg [15:0] cnt_q;
    reg [3:0]  tx_idx_q;

    wire [15:0] rx_crc;
    wire [15:0] tx_crc;

    // reset released through two flops
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    wire st_idle  = state_q == ST_IDLE;
    wire st_check = state_q == ST_CHECK;
    wire st_tx    = state_q == ST_TX;

    wire [7:0]  q_addr  = buf_q[0];
    wire [7:0]  q_func  = buf_q[1];
    wire [15:0] q_start = {buf_q[2], buf_q[3]};
    wire [15:0] q_cnt   = {buf_q[4], buf_q[5]};
    wire [7:0]  q_bc    = buf_q[6];
    wire [15:0] len16   = {{(16 - LEN_W){1'b0}}, len_q};

    function is_fn;
        input [7:0] f;
        input [7:0] code;
        begin
            is_fn = (f == code);
        end
    endfunction

    function [BUF_AW-1:0] bi;
        input [15:0] i;
        begin
            bi = i[BUF_AW-1:0];
        end
    endfunction

    wire fn_reg   = is_fn(q_func, `MBWC_FN_WR_REG);
    wire fn_coils = is_fn(q_func, `MBWC_FN_WR_COILS);
    wire fn_regs  = is_fn(q_func, `MBWC_FN_WR_REGS);

    // residue of zero over data plus received crc means intact
    wire crc_ok   = (rx_crc == 16'h0000) && (len16 >= `MBWC_LEN_MIN); // RULE_17
    wire bcast    = q_addr == `MBWC_BCAST_ADDR;
    wire addr_hit = bcast || (q_addr == slave_addr);

    wire [15:0] exp_len    = `MBWC_LEN_MULTI + {8'h00, q_bc};
    wire [15:0] coil_bytes = (q_cnt + 16'h0007) >> 3;
    wire        len_multi  = (len16 == exp_len) && (q_cnt != 16'h0000);
    // count field is bytes; each register takes two
    wire fmt_regs  = len_multi && ({8'h00, q_bc} == {q_cnt[14:0], 1'b0}); // RULE_04
    // an extra pad byte is tolerated for even pairing
    wire fmt_coils = len_multi && ({5'h00, q_bc, 3'h0} >= q_cnt)
                     && ({8'h00, q_bc} <= coil_bytes + 16'h0001); // RULE_02
    wire fmt_ok    = fn_reg ? (len16 == `MBWC_LEN_SINGLE) :
                     fn_regs ? fmt_regs : fmt_coils;
    wire is_commit = fn_reg && (q_start == `MBWC_COMMIT_REG);

    // value of item i, taken from the held query
    function [15:0] item_val;
        input [15:0] i;
        reg   [15:0] p;
        reg   [7:0]  cb;
        begin
            p  = {i[14:0], 1'b0};
            cb = buf_q[bi(16'h0007 + {3'h0, i[15:3]})];
            if (fn_reg)
                item_val = {buf_q[4], buf_q[5]};
            else if (fn_regs)
                item_val = {buf_q[bi(16'h0007 + p)], buf_q[bi(16'h0008 + p)]}; // RULE_03
            else
                item_val = {15'h0000, cb[i[2:0]]};
        end
    endfunction

    // frame store; memory needs no reset
    always @(posedge mclk) begin
        if (st_idle && rx_valid && (len_q != DEPTH[LEN_W-1:0]))
            buf_q[len_q[BUF_AW-1:0]] <= rx_byte;
    end

    mbwc_crc16 u_rx_crc (
        .clk   (mclk),
        .rst_n (rst_n_q),
        .clr   (st_check),
        .en    (st_idle && rx_valid),
        .data  (rx_byte),
        .crc_q (rx_crc)
    );

    wire [3:0] resp_n   = exc_q ? `MBWC_RESP_EXC : `MBWC_RESP_NORMAL;
    wire       tx_load  = st_tx && (!tx_valid_q || tx_ready);
    wire       tx_body  = tx_idx_q < resp_n;
    reg  [7:0] resp_byte;

    always @* begin
        resp_byte = buf_q[tx_idx_q[2:0]]; // RULE_01 RULE_05
        if (exc_q) begin
            case (tx_idx_q)
                4'h0:    resp_byte = q_addr;
                4'h1:    resp_byte = q_func | `MBWC_EXC_FLAG; // RULE_08
                default: resp_byte = exc_code_q;
            endcase
        end
    end

    mbwc_crc16 u_tx_crc (
        .clk   (mclk),
        .rst_n (rst_n_q),
        .clr   (st_check),
        .en    (tx_load && tx_body),
        .data  (resp_byte),
        .crc_q (tx_crc)
    );

    // write strobe qualifies the held item fields
    assign wr_en = state_q == ST_WRITE; // RULE_12

    wire last_item = idx_q == cnt_q - 16'h0001;
    wire bad_busy  = item_read_only || drive_fault
                     || (item_run_locked && drive_running);

    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q           <= ST_IDLE;
            len_q             <= {LEN_W{1'b0}};
            ovf_q             <= 1'b0;
            exc_q             <= 1'b0;
            exc_code_q        <= 8'h00;
            bcast_q           <= 1'b0;
            idx_q             <= 16'h0000;
            cnt_q             <= 16'h0000;
            tx_idx_q          <= 4'h0;
            tx_byte_q         <= 8'h00;
            tx_valid_q        <= 1'b0;
            tx_last_q         <= 1'b0;
            item_addr_q       <= 16'h0000;
            item_value_q      <= 16'h0000;
            item_coil_q       <= 1'b0;
            nv_commit_start_q <= 1'b0;
        end else begin
            nv_commit_start_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (rx_valid) begin
                        if (len_q == DEPTH[LEN_W-1:0])
                            ovf_q <= 1'b1;
                        else
                            len_q <= len_q + {{(LEN_W-1){1'b0}}, 1'b1};
                    end
                    if (rx_frame_end && (len_q != {LEN_W{1'b0}} || rx_valid))
                        state_q <= ST_CHECK;
                end
                ST_CHECK: begin
                    len_q    <= {LEN_W{1'b0}};
                    ovf_q    <= 1'b0;
                    bcast_q  <= bcast;
                    exc_q    <= 1'b0;
                    tx_idx_q <= 4'h0;
                    if (!crc_ok || ovf_q || !addr_hit) begin
                        state_q <= ST_IDLE; // RULE_17
                    end else if (bcast && fn_regs) begin
                        state_q <= ST_IDLE; // RULE_06
                    end else if (!(fn_reg || fn_regs || fn_coils)) begin
                        exc_q      <= 1'b1;
                        exc_code_q <= `MBWC_EX_FUNC; // RULE_09
                        state_q    <= bcast ? ST_IDLE : ST_TX; // RULE_07
                    end else if (!fmt_ok) begin
                        exc_q      <= 1'b1;
                        exc_code_q <= `MBWC_EX_FORMAT; // RULE_09
                        state_q    <= bcast ? ST_IDLE : ST_TX;
                    end else if (is_commit) begin
                        if (drive_running || drive_fault) begin
                            exc_q      <= 1'b1;
                            exc_code_q <= `MBWC_EX_BUSY; // RULE_11
                        end else begin
                            nv_commit_start_q <= 1'b1; // RULE_13
                        end
                        state_q <= bcast ? ST_IDLE : ST_TX;
                    end else begin
                        idx_q        <= 16'h0000;
                        cnt_q        <= fn_reg ? 16'h0001 : q_cnt;
                        item_addr_q  <= q_start;
                        item_value_q <= item_val(16'h0000);
                        item_coil_q  <= fn_coils;
                        state_q      <= ST_VALID;
                    end
                end
                ST_VALID: begin
                    // nothing is written unless every item passes
                    if (!item_exists || !item_in_range || bad_busy) begin
                        exc_q   <= 1'b1;
                        state_q <= bcast_q ? ST_IDLE : ST_TX;
                        if (!item_exists)
                            exc_code_q <= `MBWC_EX_ADDR; // RULE_09
                        else if (bad_busy)
                            exc_code_q <= `MBWC_EX_BUSY; // RULE_11
                        else
                            exc_code_q <= `MBWC_EX_RANGE; // RULE_10
                    end else if (last_item) begin
                        idx_q        <= 16'h0000;
                        item_addr_q  <= q_start;
                        item_value_q <= item_val(16'h0000);
                        state_q      <= ST_WRITE;
                    end else begin
                        idx_q        <= idx_q + 16'h0001;
                        item_addr_q  <= q_start + idx_q + 16'h0001;
                        item_value_q <= item_val(idx_q + 16'h0001);
                    end
                end
                ST_WRITE: begin
                    if (last_item) begin
                        state_q <= bcast_q ? ST_IDLE : ST_TX;
                    end else begin
                        idx_q        <= idx_q + 16'h0001;
                        item_addr_q  <= q_start + idx_q + 16'h0001;
                        item_value_q <= item_val(idx_q + 16'h0001);
                    end
                end
                ST_TX: begin
                    if (tx_load) begin
                        if (tx_idx_q == resp_n + 4'h2) begin
                            tx_valid_q <= 1'b0;
                            tx_last_q  <= 1'b0;
                            exc_q      <= 1'b0;
                            state_q    <= ST_IDLE;
                        end else begin
                            tx_valid_q <= 1'b1;
                            tx_idx_q   <= tx_idx_q + 4'h1;
                            tx_last_q  <= tx_idx_q == resp_n + 4'h1;
                            if (tx_body)
                                tx_byte_q <= resp_byte;
                            else if (tx_idx_q == resp_n)
                                tx_byte_q <= tx_crc[7:0];
                            else
                                tx_byte_q <= tx_crc[15:8];
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // a new start wins over a completion in the same cycle
    always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q)
            commit_progress_flag_q <= 1'b0;
        else if (nv_commit_start_q)
            commit_progress_flag_q <= 1'b1; // RULE_14 RULE_16
        else if (nv_commit_done)
            commit_progress_flag_q <= 1'b0; // RULE_16
    end
endmodule // mbwc_top
`default_nettype wire

// ---- tb/mbwc_props.sv ----
// port checker for the query handler
`timescale 1ns/1ps
`default_nettype none
module mbwc_props (
    input wire        mclk,
    input wire        rst_b,
    input wire [7:0]  slave_addr,
    input wire [7:0]  rx_byte,
    input wire        rx_valid,
    input wire        rx_frame_end,
    input wire [7:0]  tx_byte_q,
    input wire        tx_valid_q,
    input wire        tx_last_q,
    input wire        tx_ready,
    input wire        drive_running,
    input wire        drive_fault,
    input wire [15:0] item_addr_q,
    input wire [15:0] item_value_q,
    input wire        item_coil_q,
    input wire        item_exists,
    input wire        item_read_only,
    input wire        item_run_locked,
    input wire        item_in_range,
    input wire        wr_en,
    input wire        nv_commit_start_q,
    input wire        nv_commit_done,
    input wire        commit_progress_flag_q
);
    reg [3:0] idx_q;
    reg       exc_q;
    // byte index inside the reply, kept to judge frame length
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q <= 4'h0;
            exc_q <= 1'b0;
        end else if (tx_valid_q && tx_ready) begin
            idx_q <= tx_last_q ? 4'h0 : idx_q + 4'h1;
            if (idx_q == 4'h1)
                exc_q <= tx_byte_q[7];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_start; nv_commit_start_q; endsequence
    sequence s_busy; commit_progress_flag_q && !nv_commit_start_q; endsequence
    property p_tx_hold; tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_byte_q) && $stable(tx_last_q); endproperty
    property p_first_addr; tx_valid_q && idx_q == 4'h0 |-> tx_byte_q == slave_addr; endproperty
    property p_len; tx_valid_q && tx_last_q |-> (exc_q && idx_q == 4'h4) || (!exc_q && idx_q == 4'h7); endproperty
    property p_start_pulse; s_start |=> !nv_commit_start_q; endproperty
    property p_flag_rise; s_start |=> s_busy; endproperty
    property p_flag_hold; commit_progress_flag_q && !nv_commit_done |=> commit_progress_flag_q; endproperty
    property p_flag_fall; s_busy ##0 nv_commit_done |=> !commit_progress_flag_q; endproperty
    property p_start_idle; nv_commit_start_q |-> !$past(drive_running) && !$past(drive_fault); endproperty
    property p_wr_ok;
        wr_en |-> item_exists && !item_read_only && item_in_range && !drive_fault && !(item_run_locked && drive_running);
    endproperty
    property p_wr_quiet; tx_valid_q |-> !wr_en; endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply byte changed before accept");
    a_first_addr: assert property (p_first_addr) else $error("reply does not start with own address");
    a_len: assert property (p_len) else $error("reply length wrong for its kind");
    a_start_pulse: assert property (p_start_pulse) else $error("commit start longer than one cycle");
    a_flag_rise: assert property (p_flag_rise) else $error("progress flag not raised");
    a_flag_hold: assert property (p_flag_hold) else $error("progress flag dropped early");
    a_flag_fall: assert property (p_flag_fall) else $error("progress flag stuck after done");
    a_start_idle: assert property (p_start_idle) else $error("commit started while running");
    a_wr_ok: assert property (p_wr_ok) else $error("refused item written");
    a_wr_quiet: assert property (p_wr_quiet) else $error("write during reply");
endmodule // mbwc_props
bind mbwc_top mbwc_props u_props (.mclk(mclk), .rst_b(rst_b), .slave_addr(slave_addr), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q),
    .tx_last_q(tx_last_q), .tx_ready(tx_ready), .drive_running(drive_running), .drive_fault(drive_fault),
    .item_addr_q(item_addr_q), .item_value_q(item_value_q), .item_coil_q(item_coil_q),
    .item_exists(item_exists), .item_read_only(item_read_only), .item_run_locked(item_run_locked),
    .item_in_range(item_in_range), .wr_en(wr_en), .nv_commit_start_q(nv_commit_start_q),
    .nv_commit_done(nv_commit_done), .commit_progress_flag_q(commit_progress_flag_q));
`default_nettype wire

// ---- tb/mbwc_far_model.sv ----
// reply sink, item map and slow storage standing beside the handler
`timescale 1ns/1ps
`default_nettype none
module mbwc_far_model (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [15:0] item_addr_q,
    input  wire logic [15:0] item_value_q,
    input  wire logic        item_coil_q,
    input  wire logic        nv_commit_start_q,
    output var  logic        tx_ready,
    output wire logic        item_exists,
    output wire logic        item_read_only,
    output wire logic        item_run_locked,
    output wire logic        item_in_range,
    output var  logic        nv_commit_done
);
    integer     seed;
    logic [8:0] cnt_q;
    initial seed = 23;
    assign item_exists     = item_addr_q < 16'h0100 || item_addr_q == 16'h0900;
    assign item_read_only  = item_addr_q[15:4] == 12'h001;
    assign item_run_locked = item_addr_q == 16'h0050;
    assign item_in_range   = item_coil_q || item_value_q != 16'hFFFF;
    // storing is slow on purpose so the flag is seen after the reply
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready       <= 1'b0;
            nv_commit_done <= 1'b0;
            cnt_q          <= 9'h000;
        end else begin
            tx_ready       <= ($random(seed) & 3) != 0;
            nv_commit_done <= cnt_q == 9'h001;
            if (nv_commit_start_q)
                cnt_q <= 9'h12C;
            else if (cnt_q != 9'h000)
                cnt_q <= cnt_q - 9'h001;
        end
    end
endmodule // mbwc_far_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the query handler
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk, rst_b, rx_valid, rx_frame_end, drive_running, drive_fault;
    logic [7:0]  slave_addr, rx_byte;
    wire  [7:0]  tx_byte_q;
    wire  [15:0] item_addr_q, item_value_q;
    wire         tx_valid_q, tx_last_q, tx_ready, item_coil_q, wr_en, nv_commit_start_q, nv_commit_done;
    wire         item_exists, item_read_only, item_run_locked, item_in_range, commit_progress_flag_q;
    integer      seed, failures, checks, wr_cnt, tno, t, n;
    logic [7:0]  q[$];
    logic [15:0] vals[0:3], wa[0:7], wv[0:7], st;
    logic [7:0]  wc;
    mbwc_top u_mbwc_top (.mclk(mclk), .rst_b(rst_b), .slave_addr(slave_addr), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q),
        .tx_last_q(tx_last_q), .tx_ready(tx_ready), .drive_running(drive_running), .drive_fault(drive_fault),
        .item_addr_q(item_addr_q), .item_value_q(item_value_q), .item_coil_q(item_coil_q),
        .item_exists(item_exists), .item_read_only(item_read_only), .item_run_locked(item_run_locked),
        .item_in_range(item_in_range), .wr_en(wr_en), .nv_commit_start_q(nv_commit_start_q),
        .nv_commit_done(nv_commit_done), .commit_progress_flag_q(commit_progress_flag_q));
    mbwc_far_model u_mbwc_far_model (.mclk(mclk), .rst_b(rst_b), .item_addr_q(item_addr_q),
        .item_value_q(item_value_q), .item_coil_q(item_coil_q), .nv_commit_start_q(nv_commit_start_q),
        .tx_ready(tx_ready), .item_exists(item_exists), .item_read_only(item_read_only),
        .item_run_locked(item_run_locked), .item_in_range(item_in_range), .nv_commit_done(nv_commit_done));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // mid-cycle: strobe and item fields have settled
    always @(negedge mclk) if (wr_en === 1'b1) begin
        if (wr_cnt < 8) begin
            wa[wr_cnt] = item_addr_q;
            wv[wr_cnt] = item_value_q;
            wc[wr_cnt] = item_coil_q;
        end
        wr_cnt = wr_cnt + 1;
    end
    function logic [15:0] crc_of(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task check(input string nm, input logic [15:0] seen, input logic [15:0] want);
        checks = checks + 1;
        if (seen !== want) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task chk_wr(input logic [15:0] sa, input integer k, input logic cl);
        for (int i = 0; i < k && i < 8; i++) begin
            check("write addr", wa[i], sa + 16'(i));
            check("write value", wv[i], cl ? {15'h0000, q[7][i]} : vals[i]);
            check("write kind", {15'h0000, wc[i]}, {15'h0000, cl});
        end
    endtask
    task hdr(input logic [7:0] a, input logic [7:0] fn, input logic [15:0] st, input logic [15:0] cnt);
        q = {a, fn, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
    endtask
    task wregs(input logic [7:0] a, input logic [15:0] st, input integer k, input logic [7:0] bc);
        hdr(a, 8'h10, st, k[15:0]);
        q.push_back(bc);
        for (int i = 0; i < k; i++) q = {q, vals[i][15:8], vals[i][7:0]};
    endtask
    // code 0 means a normal echo reply; silent queries must draw no byte at all
    task run(input logic [7:0] code, input integer silent, input integer bad);
        logic [7:0]  e[$];
        logic [7:0]  got[$];
        logic [15:0] c;
        integer      done;
        e = {};
        got = {};
        if (!silent) begin
            if (code == 8'h00) e = q[0:5];
            else e = {q[0], q[1] | 8'h80, code};
            c = crc_of(e);
            e = {e, c[7:0], c[15:8]};
        end
        c = crc_of(q);
        q = {q, c[7:0], c[15:8] ^ (bad ? 8'h01 : 8'h00)};
        wr_cnt = 0;
        foreach (q[i]) begin
            @(posedge mclk);
            rx_byte <= q[i];
            rx_valid <= 1'b1;
            rx_frame_end <= i == q.size() - 1;
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_frame_end <= 1'b0;
        done = 0;
        for (int w = 0; w < 300 && done == 0; w++) begin
            @(negedge mclk);
            if (tx_valid_q === 1'b1 && tx_ready === 1'b1) begin
                got.push_back(tx_byte_q);
                if (tx_last_q === 1'b1) done = 1;
            end
        end
        if (!silent && done == 0) begin
            failures = failures + 1;
            tally_and_finish();
        end
        check("reply length", 16'(got.size()), 16'(e.size()));
        foreach (e[i]) if (i < got.size()) check("reply byte", {8'h00, got[i]}, {8'h00, e[i]});
        repeat (3) @(posedge mclk);
        tno = tno + 1;
        $display("test %0d ended", tno);
    endtask
    initial begin
        seed = 22;
        failures = 0;
        checks = 0;
        tno = 0;
        rst_b = 1'b0;
        slave_addr = 8'h05;
        rx_byte = 8'h00;
        {rx_valid, rx_frame_end, drive_running, drive_fault} = 4'h0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        vals[0] = 16'h0004;
        vals[1] = 16'h93E0;
        wregs(8'h05, 16'h0024, 2, 8'h04);
        run(8'h00, 0, 0);
        check("writes", wr_cnt[15:0], 16'h0002);
        chk_wr(16'h0024, 2, 1'b0);
        hdr(8'h05, 8'h0F, 16'h0007, 16'h0006);
        q = {q, 8'h02, 8'h17, 8'h00};
        run(8'h00, 0, 0);
        check("coil writes", wr_cnt[15:0], 16'h0006);
        chk_wr(16'h0007, 6, 1'b1);
        wregs(8'h05, 16'h0024, 2, 8'h02);
        run(8'h03, 0, 0);
        hdr(8'h05, 8'h08, 16'h0000, 16'h0000);
        run(8'h01, 0, 0);
        vals[0] = 16'h0001;
        wregs(8'h05, 16'h0200, 1, 8'h02);
        run(8'h02, 0, 0);
        wregs(8'h05, 16'h0010, 1, 8'h02);
        run(8'h22, 0, 0);
        vals[0] = 16'hFFFF;
        wregs(8'h05, 16'h0030, 1, 8'h02);
        run(8'h21, 0, 0);
        vals[0] = 16'h0001;
        drive_fault <= 1'b1;
        wregs(8'h05, 16'h0030, 1, 8'h02);
        run(8'h22, 0, 0);
        drive_fault <= 1'b0;
        drive_running <= 1'b1;
        wregs(8'h05, 16'h0050, 1, 8'h02);
        run(8'h22, 0, 0);
        hdr(8'h05, 8'h06, 16'h0900, 16'h1234);
        run(8'h22, 0, 0);
        drive_running <= 1'b0;
        hdr(8'h05, 8'h06, 16'h0900, 16'hABCD);
        run(8'h00, 0, 0);
        check("progress flag", {15'h0000, commit_progress_flag_q}, 16'h0001);
        for (int w = 0; w < 400 && commit_progress_flag_q !== 1'b0; w++) @(posedge mclk);
        check("progress flag", {15'h0000, commit_progress_flag_q}, 16'h0000);
        wregs(8'h00, 16'h0024, 1, 8'h02);
        run(8'h00, 1, 0);
        hdr(8'h00, 8'h0F, 16'h0007, 16'h0006);
        q = {q, 8'h02, 8'h17, 8'h00};
        run(8'h00, 1, 0);
        check("broadcast writes", wr_cnt[15:0], 16'h0006);
        chk_wr(16'h0007, 6, 1'b1);
        wregs(8'h05, 16'h0024, 1, 8'h02);
        run(8'h00, 1, 1);
        check("dropped writes", wr_cnt[15:0], 16'h0000);
        wregs(8'h09, 16'h0024, 1, 8'h02);
        run(8'h00, 1, 0);
        for (t = 0; t < 4; t++) begin
            n = 1 + ($random(seed) & 3);
            for (int i = 0; i < 4; i++) vals[i] = $random(seed) & 16'hFFFE;
            st = 16'h0020 + 16'($random(seed) & 16'h001F);
            wregs(8'h05, st, n, 8'(2 * n));
            run(8'h00, 0, 0);
            check("random writes", wr_cnt[15:0], n[15:0]);
            chk_wr(st, n, 1'b0);
        end
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
